// ### logic/plc_pkg.sv
package plc_pkg;

  // Register offsets on the configuration port.
  localparam logic [7:0] PLC_CTRL_OFS = 8'h00;
  localparam logic [7:0] PLC_LUT_OFS = 8'h04;
  localparam logic [7:0] PLC_ARITH_OFS = 8'h08;
  localparam logic [7:0] PLC_ROW_OFS = 8'h0c;
  localparam logic [7:0] PLC_STAT_OFS = 8'h10;

  // Field positions inside the control register.
  localparam int PLC_MODE_LSB = 0;
  localparam int PLC_ARR_LSB = 2;
  localparam int PLC_FFT_LSB = 5;
  localparam int PLC_BYPASS_BIT = 7;
  localparam int PLC_CARRY4_BIT = 8;
  localparam int PLC_LOCREG_BIT = 9;
  localparam int PLC_GLBREG_BIT = 10;
  localparam int PLC_PACK_BIT = 11;
  localparam int PLC_CHIPRST_BIT = 12;
  localparam int PLC_CEA_BIT = 13;
  localparam int PLC_CASCOR_BIT = 14;
  localparam int PLC_PREINV_BIT = 15;

  // Values after reset.
  localparam logic [15:0] PLC_CTRL_RST = 16'h0000;
  localparam logic [15:0] PLC_LUT_RST = 16'h0000;
  localparam logic [15:0] PLC_ARITH_RST = 16'h0000;
  localparam logic [3:0] PLC_ROW_RST = 4'h0;

  // Operating modes of the cell.
  typedef enum logic [1:0] {PLC_NORMAL, PLC_ARITH, PLC_UPDN, PLC_CLRCNT} plc_mode_e;

  // Clear and preset arrangements of the cell register.
  typedef enum logic [2:0] {PLC_A_CLR, PLC_A_PRE, PLC_A_CLRPRE, PLC_A_LDCLR, PLC_A_LDPRE,
                            PLC_A_LD, PLC_A_RSV6, PLC_A_RSV7} plc_arr_e;

  // Flip-flop behaviours of the cell register.
  typedef enum logic [1:0] {PLC_FF_D, PLC_FF_T, PLC_FF_JK, PLC_FF_SR} plc_fft_e;

endpackage : plc_pkg

// ### logic/plc_cell.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
// Functional notes
// [R1] Normal mode: four-input table, third input selectable.
// [R2] Table output combined with cascade-in to cascade-out.
// [R3] Local and global outputs pick register or table.
// [R4] Packed register loads from input d under D behaviour.
// [R5] Packed register keeps enable, clear and preset.
// [R6] Arithmetic mode: sum table and carry table.
// [R7] Cascade chain usable during arithmetic mode.
// [R8] Up/down counter with enables, direction, load.
// [R9] Counter loads through clear and preset too.
// [R10] Clearable counter: cascade-in clears, ANDed after mux.
// [R11] Emulated bus: contention low, no driver high.
// [R12] Clear and preset active low, unused held high.
// [R13] Six clear, preset and load arrangements.
// [R14] Clear-only: either group line clears.
// [R15] Async load copies input c via preset and clear.
// [R16] Chip reset overrides every other control.
// [R17] Preset-only: load one, or inverted clear.
// [R18] Clear-and-preset: first presets, second clears.
// [R19] Load-with-clear: second acts on clear only.
// [R20] Load-with-preset: stored inverted, load data inverted.
// [R21] Row channels fed by dual four-input multiplexers.
// [R22] Clock enable in every mode, from input a.
// [R23] D, T, JK, SR behaviour or register bypass.
// [R24] Register updates on enabled edge without async control.
module plc_cell
  import plc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic cell_input_a_i,
  input wire logic cell_input_b_i,
  input wire logic cell_input_c_i,
  input wire logic cell_input_d_i,
  input wire logic carry_in_i,
  input wire logic cascade_in_i,
  input wire logic group_ctrl_first_n_i,
  input wire logic group_ctrl_second_n_i,
  input wire logic chip_reset_n_i,
  input wire logic [2:0] col_chan_i,
  input wire logic [3:0] bus_drv_en_i,
  input wire logic [3:0] bus_drv_data_i,
  output logic local_o,
  output logic global_o,
  output logic carry_out_o,
  output logic cascade_out_o,
  output logic [1:0] row_chan_o,
  output logic tri_bus_o
);

  // Picks one entry of a table mask.
  function automatic logic lut_pick(input logic [15:0] mask, input logic [3:0] idx);
    lut_pick = mask[idx];
  endfunction : lut_pick

  // Four-to-one selector used for both row channels.
  function automatic logic mux4(input logic [3:0] src, input logic [1:0] sel);
    mux4 = src[sel];
  endfunction : mux4

  logic [15:0] ctrl_ff; // Mode and option bits.
  logic [15:0] lut_ff; // Normal mode table.
  logic [15:0] arith_ff; // Sum table low byte, carry table high byte.
  logic [3:0] row_ff; // Row channel selects.
  logic q_int_ff; // Stored bit, possibly inverted.
  logic [31:0] nxt_rdata;
  plc_mode_e mode;
  plc_arr_e arr;
  plc_fft_e fft;
  logic inv_store; // Register holds the complement of its value.
  logic q_vis; // Register value seen by the cell.
  logic [3:0] nidx; // Normal mode table index.
  logic [2:0] aidx; // Arithmetic table index.
  logic lut_out; // Combinational result of the cell.
  logic cnt_val; // Counter next value before loading.
  logic nxt_carry;
  logic nxt_cascade;
  logic load_mux; // Output of the synchronous load multiplexer.
  logic d_vis; // Next register value in visible polarity.
  logic ce; // Synchronous clock enable.
  logic g1, g2; // Group lines, active high inside.
  logic pre_n, clr_n; // Register asynchronous controls.
  logic loc_val, glb_val;
  logic nxt_bus;

  assign mode = plc_mode_e'(ctrl_ff[PLC_MODE_LSB +: 2]);
  assign arr = plc_arr_e'(ctrl_ff[PLC_ARR_LSB +: 3]);
  assign fft = plc_fft_e'(ctrl_ff[PLC_FFT_LSB +: 2]);
  assign g1 = ~group_ctrl_first_n_i;
  assign g2 = ~group_ctrl_second_n_i;

  // Storage is inverted for load-with-preset, and for preset-only when the inverted form is chosen.
  assign inv_store = (arr == PLC_A_LDPRE) || ((arr == PLC_A_PRE) && ctrl_ff[PLC_PREINV_BIT]); // R17 R20
  assign q_vis = q_int_ff ^ inv_store;

  // Configuration writes.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= PLC_CTRL_RST;
      lut_ff <= PLC_LUT_RST;
      arith_ff <= PLC_ARITH_RST;
      row_ff <= PLC_ROW_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == PLC_CTRL_OFS) begin
        ctrl_ff <= reg_wdata_i[15:0];
      end else if (reg_addr_i == PLC_LUT_OFS) begin
        lut_ff <= reg_wdata_i[15:0];
      end else if (reg_addr_i == PLC_ARITH_OFS) begin
        arith_ff <= reg_wdata_i[15:0];
      end else if (reg_addr_i == PLC_ROW_OFS) begin
        row_ff <= reg_wdata_i[3:0];
      end
    end
  end

  // Read mux; unmapped offsets return zero.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_addr_i == PLC_CTRL_OFS) begin
      nxt_rdata = {16'h0000, ctrl_ff};
    end else if (reg_addr_i == PLC_LUT_OFS) begin
      nxt_rdata = {16'h0000, lut_ff};
    end else if (reg_addr_i == PLC_ARITH_OFS) begin
      nxt_rdata = {16'h0000, arith_ff};
    end else if (reg_addr_i == PLC_ROW_OFS) begin
      nxt_rdata = {28'h0000000, row_ff};
    end else if (reg_addr_i == PLC_STAT_OFS) begin
      nxt_rdata = {23'h000000, tri_bus_o, row_chan_o, cascade_out_o, carry_out_o,
                   global_o, local_o, lut_out, q_vis};
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // Table indices for the normal and arithmetic forms.
  always_comb begin
    // Third table input is carry-in or input c.
    nidx[2] = ctrl_ff[PLC_CARRY4_BIT] ? carry_in_i : cell_input_c_i; // R1
    nidx[1] = cell_input_b_i;
    nidx[0] = cell_input_a_i;
    // A packed register takes input d under D behaviour, and the table sees only three inputs.
    nidx[3] = ctrl_ff[PLC_PACK_BIT] ? 1'b0 : cell_input_d_i; // R4
    aidx = {carry_in_i, cell_input_b_i, cell_input_a_i};
  end

  // Combinational function, carry and cascade per mode.
  always_comb begin
    lut_out = 1'b0;
    nxt_carry = 1'b0;
    cnt_val = q_vis;
    case (mode)
      PLC_NORMAL: begin
        lut_out = lut_pick(lut_ff, nidx); // R1
      end
      PLC_ARITH: begin
        // Sum and carry tables share carry-in and two data inputs.
        lut_out = lut_pick({8'h00, arith_ff[7:0]}, {1'b0, aidx}); // R6
        nxt_carry = lut_pick({8'h00, arith_ff[15:8]}, {1'b0, aidx}); // R6
      end
      default: begin
        // Counter bit toggles when enabled and the lower bits ripple in.
        cnt_val = q_vis ^ (cell_input_b_i & carry_in_i); // R8
        lut_out = cnt_val;
        if ((mode == PLC_UPDN) && !cascade_in_i) begin
          // Down count when direction input is low.
          nxt_carry = ~q_vis & carry_in_i; // R8
        end else begin
          nxt_carry = q_vis & carry_in_i;
        end
      end
    endcase
    // Cascade joins by AND, or by plain OR when the cascade-OR bit is set.
    if (ctrl_ff[PLC_CASCOR_BIT]) begin
      nxt_cascade = lut_out | cascade_in_i; // R2 R7
    end else begin
      nxt_cascade = lut_out & cascade_in_i; // R2 R7
    end
  end

  // Next register value in visible polarity.
  always_comb begin
    // Load multiplexer picks input c when input d requests a load.
    load_mux = cell_input_d_i ? cell_input_c_i : cnt_val; // R8
    d_vis = q_vis;
    if ((mode == PLC_UPDN) || (mode == PLC_CLRCNT)) begin
      d_vis = load_mux; // R8
      if (mode == PLC_CLRCNT) begin
        // Cascade input works as an active-low synchronous clear.
        d_vis = load_mux & cascade_in_i; // R10
      end
    end else begin
      case (fft) // R23
        PLC_FF_D: d_vis = ctrl_ff[PLC_PACK_BIT] ? cell_input_d_i : lut_out; // R4
        PLC_FF_T: d_vis = q_vis ^ lut_out;
        PLC_FF_JK: d_vis = (lut_out & ~q_vis) | (~cell_input_d_i & q_vis);
        default: d_vis = lut_out | (~cell_input_d_i & q_vis);
      endcase
    end
  end

  // Clock enable comes from input a when selected.
  assign ce = ctrl_ff[PLC_CEA_BIT] ? cell_input_a_i : 1'b1; // R22 R5

  // Active-low clear and preset for each arrangement; unused ones stay high.
  always_comb begin
    pre_n = 1'b1; // R12
    clr_n = 1'b1; // R12
    case (arr) // R13
      PLC_A_CLR: begin
        clr_n = ~(g1 | g2); // R14
      end
      PLC_A_PRE: begin
        if (ctrl_ff[PLC_PREINV_BIT]) begin
          clr_n = ~g1; // R17
        end else begin
          pre_n = ~g1; // R17
        end
      end
      PLC_A_CLRPRE: begin
        pre_n = ~g1; // R18
        clr_n = ~g2; // R18
      end
      PLC_A_LDCLR: begin
        pre_n = ~(g1 & cell_input_c_i); // R15 R19
        clr_n = ~((g1 & ~cell_input_c_i) | g2); // R19
      end
      PLC_A_LDPRE: begin
        // Internal bit takes the inverted load data.
        pre_n = ~(g1 & ~cell_input_c_i); // R20
        clr_n = ~((g1 & cell_input_c_i) | g2); // R20
      end
      PLC_A_LD: begin
        pre_n = ~(g1 & cell_input_c_i); // R15 R9
        clr_n = ~(g1 & ~cell_input_c_i); // R15 R9
      end
      default: begin
        pre_n = 1'b1;
        clr_n = 1'b1;
      end
    endcase
  end

  // Cell register; chip reset first, then clear, preset, then the enabled update.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      q_int_ff <= 1'b0;
    end else if (ctrl_ff[PLC_CHIPRST_BIT] && !chip_reset_n_i) begin
      q_int_ff <= 1'b0; // R16
    end else if (!clr_n) begin
      q_int_ff <= 1'b0; // R9 R5
    end else if (!pre_n) begin
      q_int_ff <= 1'b1; // R9 R5
    end else if (ce && !ctrl_ff[PLC_BYPASS_BIT]) begin
      q_int_ff <= d_vis ^ inv_store; // R24
    end
  end

  // Output sources; bypass routes the table straight out.
  always_comb begin
    loc_val = (ctrl_ff[PLC_LOCREG_BIT] && !ctrl_ff[PLC_BYPASS_BIT]) ? q_vis : lut_out; // R3 R23
    glb_val = (ctrl_ff[PLC_GLBREG_BIT] && !ctrl_ff[PLC_BYPASS_BIT]) ? q_vis : lut_out; // R3 R23
  end

  // Registered cell outputs.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      local_o <= 1'b0;
      global_o <= 1'b0;
    end else begin
      local_o <= loc_val; // R3
      global_o <= glb_val; // R3
    end
  end

  // Registered chain outputs; cascade idles high.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      carry_out_o <= 1'b0;
      cascade_out_o <= 1'b1;
    end else begin
      carry_out_o <= nxt_carry; // R6
      cascade_out_o <= nxt_cascade; // R2
    end
  end

  // Row channels, each from the cell or one of three column channels.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      row_chan_o <= 2'h0;
    end else begin
      row_chan_o[0] <= mux4({col_chan_i, glb_val}, row_ff[1:0]); // R21
      row_chan_o[1] <= mux4({col_chan_i, glb_val}, row_ff[3:2]); // R21
    end
  end

  // Bus resolution: one driver passes, contention low, none high.
  always_comb begin
    nxt_bus = 1'b1; // R11
    if ((bus_drv_en_i & (bus_drv_en_i - 4'h1)) != 4'h0) begin
      nxt_bus = 1'b0; // R11
    end else if (bus_drv_en_i != 4'h0) begin
      nxt_bus = |(bus_drv_en_i & bus_drv_data_i);
    end
  end

  // Registered bus value.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tri_bus_o <= 1'b1;
    end else begin
      tri_bus_o <= nxt_bus;
    end
  end

endmodule : plc_cell

// ### bench/plc_cell_asserts.sv
`timescale 1ns/100ps
// Watches the cell ports and keeps copies of the configuration it needs.
module plc_cell_chk
  import plc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic cell_input_a_i,
  input wire logic cell_input_b_i,
  input wire logic cell_input_c_i,
  input wire logic carry_in_i,
  input wire logic cascade_in_i,
  input wire logic group_ctrl_first_n_i,
  input wire logic group_ctrl_second_n_i,
  input wire logic chip_reset_n_i,
  input wire logic [2:0] col_chan_i,
  input wire logic [3:0] bus_drv_en_i,
  input wire logic [3:0] bus_drv_data_i,
  input wire logic local_o,
  input wire logic carry_out_o,
  input wire logic cascade_out_o,
  input wire logic [1:0] row_chan_o,
  input wire logic tri_bus_o
);
  default clocking dck @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [15:0] ctrl_ff; // Copy of the control register.
  logic [15:0] arith_ff; // Copy of the arithmetic tables.
  logic [3:0] row_ff; // Copy of the row selects.
  logic [2:0] arr; // Selected clear and preset arrangement.
  logic vis; // Plain register shown on local, no chip reset pending.
  // Follows configuration writes at the same edge the cell takes them.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= 16'h0000;
      arith_ff <= 16'h0000;
      row_ff <= 4'h0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == PLC_CTRL_OFS) ctrl_ff <= reg_wdata_i[15:0];
      if (reg_addr_i == PLC_ARITH_OFS) arith_ff <= reg_wdata_i[15:0];
      if (reg_addr_i == PLC_ROW_OFS) row_ff <= reg_wdata_i[3:0];
    end
  end
  assign arr = ctrl_ff[4:2];
  assign vis = ctrl_ff[9] && !ctrl_ff[7] && !ctrl_ff[15] && !(ctrl_ff[12] && !chip_reset_n_i);
  AST_BUS:
    assert property (1'b1 |=> tri_bus_o == $past(bus_drv_en_i == 4'h0
      || ($onehot(bus_drv_en_i) && |(bus_drv_en_i & bus_drv_data_i)))) else $error("bus value wrong");
  AST_RDATA_IDLE:
    assert property (!reg_rd_i |=> reg_rdata_o == 32'h0) else $error("read data not idle");
  AST_CASC:
    assert property (!ctrl_ff[1] && ctrl_ff[14] == cascade_in_i |=> cascade_out_o == $past(cascade_in_i))
      else $error("cascade out wrong");
  AST_CARRY:
    assert property (ctrl_ff[1:0] == PLC_ARITH |=> carry_out_o ==
      $past(arith_ff[8 + {carry_in_i, cell_input_b_i, cell_input_a_i}])) else $error("carry out wrong");
  AST_ROW:
    assert property (row_ff[1:0] != 2'h0 |=> row_chan_o[0] == $past(col_chan_i[row_ff[1:0] - 2'h1]))
      else $error("row channel wrong");
  AST_CLR:
    assert property ((vis && arr == PLC_A_CLR && !(group_ctrl_first_n_i && group_ctrl_second_n_i))[*2]
      |=> !local_o) else $error("clear missed");
  AST_LOAD:
    assert property ((vis && (arr == PLC_A_LD || arr == PLC_A_LDCLR) && !group_ctrl_first_n_i
      && group_ctrl_second_n_i && cell_input_c_i)[*2] |=> local_o) else $error("load missed");
  AST_CLRPRE:
    assert property ((vis && arr == PLC_A_CLRPRE && !group_ctrl_first_n_i && group_ctrl_second_n_i)[*2]
      |=> local_o) else $error("preset missed");
  AST_LDPRE:
    assert property ((vis && arr == PLC_A_LDPRE && !group_ctrl_second_n_i)[*2] |=> local_o)
      else $error("inverted preset missed");
  AST_HOLD:
    assert property ((vis && ctrl_ff[13] && !cell_input_a_i && group_ctrl_first_n_i
      && group_ctrl_second_n_i)[*3] |-> $stable(local_o)) else $error("register moved while disabled");
  AST_CHIPRST:
    assert property ((ctrl_ff[12] && !chip_reset_n_i && ctrl_ff[9] && !ctrl_ff[7] && !ctrl_ff[15]
      && arr != PLC_A_LDPRE)[*2] |=> !local_o) else $error("chip reset missed");
endmodule : plc_cell_chk

bind plc_cell plc_cell_chk i_plc_cell_chk (.*);

// ### bench/plc_nbr.sv
`timescale 1ns/100ps
// Stands in for the lower neighbour cell on the carry and cascade chains.
module plc_nbr (
  input wire logic core_clk_i,
  input wire logic [1:0] drv_i, // Wanted carry and cascade values.
  output logic carry_in_o, // Carry handed to the cell.
  output logic cascade_in_o // Cascade handed to the cell.
);
  // The neighbour's registered chain outputs change just after each edge; one process drives them.
  always @(posedge core_clk_i) begin
    carry_in_o <= drv_i[1];
    cascade_in_o <= drv_i[0];
  end
endmodule : plc_nbr

// ### bench/testbench.sv
`timescale 1ns/100ps
// Drives the cell through its configuration port and cell inputs.
module testbench
  import plc_pkg::*;
;
  logic clk = 1'b0, rst_n, wr, rd, a, b, c, d, first_n, second_n, chip_n, loc, glb, cout, cascd, tbus, cin, casc;
  logic [7:0] addr; // Register offset.
  logic [31:0] wdata, rdata; // Register data.
  logic [2:0] col; // Column channels.
  logic [3:0] bus_en, bus_d; // Emulated bus drivers.
  logic [1:0] drv, row; // Neighbour request and row outputs.
  logic [11:0] steps [14] = '{12'h561, 12'h040, 12'h561, 12'h080, 12'h241, 12'h280, 12'h361,
    12'h3a0, 12'h481, 12'h440, 12'h141, 12'h0d1, 12'h0c1, 12'h0c8}; // Async control sequence.
  int seed = 71227; // Fixed seed keeps runs repeatable.
  int num_errors = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  plc_cell i_plc_cell (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .cell_input_a_i(a), .cell_input_b_i(b),
    .cell_input_c_i(c), .cell_input_d_i(d), .carry_in_i(cin), .cascade_in_i(casc),
    .group_ctrl_first_n_i(first_n), .group_ctrl_second_n_i(second_n), .chip_reset_n_i(chip_n),
    .col_chan_i(col), .bus_drv_en_i(bus_en), .bus_drv_data_i(bus_d), .local_o(loc), .global_o(glb),
    .carry_out_o(cout), .cascade_out_o(cascd), .row_chan_o(row), .tri_bus_o(tbus));
  plc_nbr i_plc_nbr (.core_clk_i(clk), .drv_i(drv), .carry_in_o(cin), .cascade_in_o(casc));
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One-cycle write strobe.
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] dat);
    @(posedge clk);
    addr <= ad;
    wdata <= dat;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // One-cycle read strobe; data is looked at in the following cycle.
  task automatic rd_reg(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask : rd_reg
  // Bus value the emulation must resolve to.
  function automatic logic [31:0] exp_bus(input logic [3:0] en, input logic [3:0] dat);
    if (en == 4'h0) return 32'h1;
    if ($onehot(en)) return 32'(|(en & dat));
    return 32'h0;
  endfunction : exp_bus
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Checked %0d samples, %0d errors", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // Main sequence.
  initial begin
    logic [15:0] lut;
    logic [31:0] r;
    logic [3:0] idx;
    logic [11:0] s;
    logic v;
    {rst_n, addr, wdata, wr, rd, a, b, c, d, drv, col, bus_en, bus_d} = '0;
    {first_n, second_n, chip_n} = 3'b111;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd_reg(8'(4 * i), (i == 4) ? 32'h100 : 32'h0);
    rd_reg(8'h14, 32'h0);
    for (int i = 1; i < 4; i++) begin
      r = $random(seed);
      wr_reg(8'(4 * i), r);
      rd_reg(8'(4 * i), r & ((i == 3) ? 32'hf : 32'hffff));
    end
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      bus_en <= (i < 16) ? 4'(i) : 4'($random(seed));
      bus_d <= 4'($random(seed));
      @(posedge clk);
      #1 chk("bus", 32'(tbus), exp_bus(bus_en, bus_d));
    end
    lut = 16'($random(seed));
    wr_reg(PLC_LUT_OFS, 32'(lut));
    for (int i = 0; i < 64; i++) begin
      if (i == 32) wr_reg(PLC_CTRL_OFS, 32'h0100);
      @(posedge clk);
      {a, b, c, d, drv} <= 6'($random(seed));
      repeat (2) @(posedge clk);
      #1 idx = {d, (i >= 32) ? cin : c, b, a};
      chk("normal", 32'({loc, glb, cascd}), 32'({lut[idx], lut[idx], lut[idx] & casc}));
    end
    wr_reg(PLC_ARITH_OFS, 32'he896);
    wr_reg(PLC_CTRL_OFS, 32'h1);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      {a, b, drv} <= 4'($random(seed));
      repeat (2) @(posedge clk);
      #1 v = a ^ b ^ cin;
      chk("arith", 32'({loc, cout, cascd}), 32'({v, a & b | cin & (a ^ b), v & casc}));
    end
    wr_reg(PLC_CTRL_OFS, 32'h0a00);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      {a, b, c, d} <= 4'($random(seed));
      repeat (2) @(posedge clk);
      #1 chk("packed", 32'({loc, glb}), 32'({d, lut[{1'b0, c, b, a}]}));
    end
    @(posedge clk);
    first_n <= 1'b0;
    d <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("packed", 32'(loc), 32'h0);
    for (int i = 0; i < 16; i++) begin
      wr_reg(PLC_ROW_OFS, 32'(i));
      @(posedge clk);
      col <= 3'($random(seed));
      @(posedge clk);
      #1 if (i[1:0] != 0) chk("row0", 32'(row[0]), 32'(col[i[1:0] - 1]));
      if (i[3:2] != 0) chk("row1", 32'(row[1]), 32'(col[i[3:2] - 1]));
    end
    wr_reg(PLC_LUT_OFS, 32'hffff);
    foreach (steps[i]) begin
      s = steps[i];
      wr_reg(PLC_CTRL_OFS, 32'h2200 | 32'(s[10:8]) << 2 | 32'(s[3]) << 12);
      @(posedge clk);
      {first_n, second_n, c, a} <= s[7:4];
      chip_n <= !s[3];
      repeat (3) @(posedge clk);
      #1 chk("async", 32'(loc), 32'(s[0]));
    end
    wr_reg(PLC_CTRL_OFS, 32'h2202);
    @(posedge clk);
    {chip_n, a, b, c, d, drv} <= 7'b1101111;
    repeat (3) @(posedge clk);
    #1 chk("count", 32'(loc), 32'h1);
    @(posedge clk);
    d <= 1'b0;
    b <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      #1 v = loc;
      @(posedge clk);
      #1 chk("count", 32'(loc), 32'(!v));
    end
    wr_reg(PLC_CTRL_OFS, 32'h2203);
    @(posedge clk);
    {a, b, c, d, drv} <= 6'b101110;
    repeat (3) @(posedge clk);
    #1 chk("clrcnt", 32'(loc), 32'h0);
    @(posedge clk);
    drv <= 2'b11;
    repeat (3) @(posedge clk);
    #1 chk("clrcnt", 32'(loc), 32'h1);
    // Bypass sends the table to both outputs; cascade joins by OR.
    wr_reg(PLC_LUT_OFS, 32'(lut));
    wr_reg(PLC_CTRL_OFS, 32'h4680);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {a, b, c, d, drv} <= 6'($random(seed));
      repeat (2) @(posedge clk);
      #1 idx = {d, c, b, a};
      chk("bypass", 32'({loc, glb, cascd}), 32'({lut[idx], lut[idx], lut[idx] | casc}));
    end
    // Toggle behaviour with the register on the global output; the table follows input a.
    wr_reg(PLC_LUT_OFS, 32'haaaa);
    wr_reg(PLC_CTRL_OFS, 32'h0420);
    @(posedge clk);
    a <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      #1 v = glb;
      @(posedge clk);
      #1 chk("toggle", 32'(glb), 32'(!v));
    end
    // Preset built from the clear with inverted storage, then a plain update through it.
    wr_reg(PLC_CTRL_OFS, 32'h8204);
    @(posedge clk);
    first_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("invpre", 32'(loc), 32'h1);
    @(posedge clk);
    {first_n, a} <= 2'b10;
    repeat (3) @(posedge clk);
    #1 chk("invpre", 32'(loc), 32'h0);
    complete_run();
  end
endmodule : testbench
